// ---- rtl/sbrg_pkg.sv ----
// Package: register map, field positions, reset values and timing constants for the baud rate generator
// Operation
// - Divider runs on the device clock, so rate follows the active clock.
// - Receive level decided by majority of three samples.
// - Rate is clock over 64(n+1), 16(n+1) or 4(n+1) per mode.
// - Divisor n is high byte over low byte in wide mode.
// - Software-accessible 8-bit divisor high byte register.
// - Software-accessible 8-bit divisor low byte register, alone used in narrow mode.
// - 40 MHz, async narrow normal, divisor 64 gives 9.615 kbaud.
// - Divider defaults to 8-bit after reset; 16-bit only when selected.
// - Any write to either divisor byte restarts the divider count.
// - In synchronous mode high-speed select has no effect.
// - Divisor sets the period of a free-running timer.
package sbrg_pkg;
    // Byte addresses of the word-aligned registers
    localparam logic [7:0] ADDR_TX_CTRL = 8'h00;
    localparam logic [7:0] ADDR_RX_CTRL = 8'h04;
    localparam logic [7:0] ADDR_RATE_CTRL = 8'h08;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h0c;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h14;
    // Field positions
    localparam int SYNC_BIT = 4;
    localparam int HIGH_SPEED_BIT = 2;
    localparam int WIDE_DIV_BIT = 3;
    // Reset values
    localparam logic [7:0] RST_TX_CTRL = 8'h00;
    localparam logic [7:0] RST_RX_CTRL = 8'h00;
    localparam logic [7:0] RST_RATE_CTRL = 8'h40;
    localparam logic [7:0] RST_DIVISOR = 8'h00;
    // Writable masks: rate control only keeps the wide divider bit here
    localparam logic [7:0] MASK_RATE_CTRL = 8'h08;
    // Prescale counts, less one
    localparam logic [5:0] PRE_64 = 6'h3f;
    localparam logic [5:0] PRE_16 = 6'h0f;
    localparam logic [5:0] PRE_4 = 6'h03;
    // Vote sample slots in the prescale count (middle of bit)
    localparam logic [5:0] VOTE_SLOT_64 = 6'h20;
    localparam logic [5:0] VOTE_SLOT_16 = 6'h08;
    localparam logic [5:0] VOTE_SLOT_4 = 6'h02;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Divider mode choice
    typedef enum logic [1:0] {
        SBRG_DIV64 = 2'b00,
        SBRG_DIV16 = 2'b01,
        SBRG_DIV4 = 2'b10
    } sbrg_mode_t;

    // Divider configuration travelling as one carrier
    typedef struct packed {
        sbrg_mode_t mode;
        logic wide;
        logic [15:0] divisor;
    } sbrg_cfg_t;
endpackage

// ---- rtl/sbrg_vote.sv ----
// Three-sample majority detector for the receive pin
`timescale 1ns/1ps
`default_nettype none
module sbrg_vote (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic rx_pin,
    input wire logic sample_strobe,
    input wire logic sample_restart,
    output logic rx_level,
    output logic vote_done
);
    logic rx_meta;
    logic rx_sync;
    logic [2:0] samples;
    logic [1:0] count;

    // Two-stage synchroniser on the asynchronous pin
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_meta <= 1'b1;
            rx_sync <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_sync <= rx_meta;
        end
    end

    // Collect three consecutive samples, then vote
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            samples <= 3'h7;
            count <= 2'h0;
            rx_level <= 1'b1;
            vote_done <= 1'b0;
        end else begin
            vote_done <= 1'b0;
            if (sample_restart) begin
                count <= 2'h0;
            end else if (sample_strobe) begin
                samples <= {samples[1:0], rx_sync};
                if (count == 2'h2) begin
                    count <= 2'h0;
                    // At least two agreeing samples win
                    rx_level <= (samples[1] & samples[0]) | (samples[1] & rx_sync)
                        | (samples[0] & rx_sync);
                    vote_done <= 1'b1;
                end else begin
                    count <= count + 2'h1;
                end
            end
        end
    end

    a_vote_majority: assert property (@(posedge aclk) disable iff (!aresetn)
        vote_done |-> rx_level == (($past(samples[0], 1) & $past(samples[1], 1))
            | ($past(samples[0], 1) & $past(rx_sync, 1)) | ($past(samples[1], 1) & $past(rx_sync, 1))))
        else $error("majority vote result wrong");
endmodule
`default_nettype wire

// ---- rtl/sbrg_top.sv ----
// Baud rate generator with AXI4-Lite register slave and receive majority vote
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module sbrg_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic rx_pin,
    output logic rate_tick,
    output logic sample_tick,
    output logic rx_level
);
    logic [7:0] tx_ctrl;
    logic [7:0] rx_ctrl;
    logic [7:0] rate_ctrl;
    logic [7:0] div_high;
    logic [7:0] div_low;
    logic aw_held;
    logic w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    logic div_written;
    logic [5:0] pre_count;
    logic [15:0] div_count;
    logic vote_done;
    logic rx_vote;
    logic sample_strobe;
    logic [5:0] vote_slot;
    sbrg_pkg::sbrg_cfg_t cfg;

    // Pick the prescale for the active mode
    function automatic logic [5:0] prescale_of(input sbrg_pkg::sbrg_mode_t m);
        case (m)
            sbrg_pkg::SBRG_DIV64: prescale_of = sbrg_pkg::PRE_64;
            sbrg_pkg::SBRG_DIV16: prescale_of = sbrg_pkg::PRE_16;
            default: prescale_of = sbrg_pkg::PRE_4;
        endcase
    endfunction

    // Mode decode; sync forces divide by 4 regardless of high speed
    always_comb begin
        cfg.wide = rate_ctrl[sbrg_pkg::WIDE_DIV_BIT];
        if (tx_ctrl[sbrg_pkg::SYNC_BIT]) begin
            cfg.mode = sbrg_pkg::SBRG_DIV4;
        end else if (cfg.wide && tx_ctrl[sbrg_pkg::HIGH_SPEED_BIT]) begin
            cfg.mode = sbrg_pkg::SBRG_DIV4;
        end else if (cfg.wide || tx_ctrl[sbrg_pkg::HIGH_SPEED_BIT]) begin
            cfg.mode = sbrg_pkg::SBRG_DIV16;
        end else begin
            cfg.mode = sbrg_pkg::SBRG_DIV64;
        end
        // Narrow mode ignores the high byte
        cfg.divisor = cfg.wide ? {div_high, div_low} : {8'h00, div_low};
    end

    // Write address and data may arrive in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end else if (wr_go) begin
                aw_held <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end else if (wr_go) begin
                w_held <= 1'b0;
            end
        end
    end

    assign wr_go = aw_held && w_held && !s_axi_bvalid;

    // Ready only while the channel slot is empty and no response waits
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
            s_axi_wready <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
        end
    end

    // Register writes and write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_ctrl <= sbrg_pkg::RST_TX_CTRL;
            rx_ctrl <= sbrg_pkg::RST_RX_CTRL;
            rate_ctrl <= sbrg_pkg::RST_RATE_CTRL & sbrg_pkg::MASK_RATE_CTRL;
            div_high <= sbrg_pkg::RST_DIVISOR;
            div_low <= sbrg_pkg::RST_DIVISOR;
            div_written <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= sbrg_pkg::RESP_OKAY;
        end else begin
            div_written <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (wr_go) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= sbrg_pkg::RESP_OKAY;
                case (aw_addr)
                    sbrg_pkg::ADDR_TX_CTRL: if (w_strb[0]) tx_ctrl <= w_data[7:0];
                    sbrg_pkg::ADDR_RX_CTRL: if (w_strb[0]) rx_ctrl <= w_data[7:0];
                    sbrg_pkg::ADDR_RATE_CTRL: if (w_strb[0]) rate_ctrl <= w_data[7:0] & sbrg_pkg::MASK_RATE_CTRL;
                    sbrg_pkg::ADDR_DIV_HIGH: begin
                        if (w_strb[0]) begin
                            div_high <= w_data[7:0];
                            div_written <= 1'b1;
                        end
                    end
                    sbrg_pkg::ADDR_DIV_LOW: begin
                        if (w_strb[0]) begin
                            div_low <= w_data[7:0];
                            div_written <= 1'b1;
                        end
                    end
                    sbrg_pkg::ADDR_STATUS: s_axi_bresp <= sbrg_pkg::RESP_OKAY;
                    default: s_axi_bresp <= sbrg_pkg::RESP_SLVERR;
                endcase
            end
        end
    end

    // Read channel: one read at a time, answered the cycle after acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= sbrg_pkg::RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
            if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= sbrg_pkg::RESP_OKAY;
                case (s_axi_araddr)
                    sbrg_pkg::ADDR_TX_CTRL: s_axi_rdata <= {24'h000000, tx_ctrl};
                    sbrg_pkg::ADDR_RX_CTRL: s_axi_rdata <= {24'h000000, rx_ctrl};
                    // Bit 6 reads the voted receive level as the line idle indication
                    sbrg_pkg::ADDR_RATE_CTRL: s_axi_rdata <= {24'h000000, 1'b0, rx_vote, rate_ctrl[5:0]};
                    sbrg_pkg::ADDR_DIV_HIGH: s_axi_rdata <= {24'h000000, div_high};
                    sbrg_pkg::ADDR_DIV_LOW: s_axi_rdata <= {24'h000000, div_low};
                    sbrg_pkg::ADDR_STATUS: s_axi_rdata <= {16'h0000, div_count};
                    default: begin
                        s_axi_rdata <= 32'h0000_0000;
                        s_axi_rresp <= sbrg_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end
    end

    // Free-running divider on the device clock; a divisor write restarts it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pre_count <= sbrg_pkg::PRE_64;
            div_count <= 16'h0000;
            rate_tick <= 1'b0;
            sample_tick <= 1'b0;
        end else begin
            rate_tick <= 1'b0;
            sample_tick <= 1'b0;
            if (div_written) begin
                pre_count <= prescale_of(cfg.mode);
                div_count <= cfg.divisor;
            end else if (div_count != 16'h0000) begin
                div_count <= div_count - 16'h0001;
            end else begin
                div_count <= cfg.divisor;
                sample_tick <= 1'b1;
                if (pre_count == 6'h00) begin
                    pre_count <= prescale_of(cfg.mode);
                    rate_tick <= 1'b1;
                end else begin
                    pre_count <= pre_count - 6'h01;
                end
            end
        end
    end

    // Vote window sits around the middle of the prescale count
    always_comb begin
        case (cfg.mode)
            sbrg_pkg::SBRG_DIV64: vote_slot = sbrg_pkg::VOTE_SLOT_64;
            sbrg_pkg::SBRG_DIV16: vote_slot = sbrg_pkg::VOTE_SLOT_16;
            default: vote_slot = sbrg_pkg::VOTE_SLOT_4;
        endcase
    end

    assign sample_strobe = sample_tick && (pre_count <= vote_slot) && (pre_count + 6'h02 >= vote_slot);

    sbrg_vote u_vote (
        .aclk(aclk),
        .aresetn(aresetn),
        .rx_pin(rx_pin),
        .sample_strobe(sample_strobe),
        .sample_restart(rate_tick),
        .rx_level(rx_vote),
        .vote_done(vote_done)
    );

    // Registered copy of the vote for the port
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rx_level <= 1'b1;
        end else if (vote_done) begin
            rx_level <= rx_vote;
        end
    end

    a_div_reload: assert property (@(posedge aclk) disable iff (!aresetn)
        $past(div_written, 1) |-> div_count == $past(cfg.divisor, 1))
        else $error("divisor write did not restart divider");
    a_div_step: assert property (@(posedge aclk) disable iff (!aresetn)
        (!div_written && div_count != 16'h0000) |=> div_count == $past(div_count, 1) - 16'h0001)
        else $error("divider did not count down");
    a_sample_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        (!div_written && div_count == 16'h0000) |=> sample_tick)
        else $error("no tick at zero");
    a_tick_only_zero: assert property (@(posedge aclk) disable iff (!aresetn)
        rate_tick |-> $past(pre_count, 1) == 6'h00 && $past(div_count, 1) == 16'h0000)
        else $error("rate tick without expiry");
    a_sync_div4: assert property (@(posedge aclk) disable iff (!aresetn)
        tx_ctrl[sbrg_pkg::SYNC_BIT] |-> cfg.mode == sbrg_pkg::SBRG_DIV4)
        else $error("sync mode not divide by four");
    a_narrow_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !rate_ctrl[sbrg_pkg::WIDE_DIV_BIT] |-> cfg.divisor[15:8] == 8'h00 && cfg.divisor[7:0] == div_low)
        else $error("narrow mode used high byte");
    a_wide_pair: assert property (@(posedge aclk) disable iff (!aresetn)
        rate_ctrl[sbrg_pkg::WIDE_DIV_BIT] |-> cfg.divisor == {div_high, div_low})
        else $error("wide divisor pairing wrong");
    a_div16_mode: assert property (@(posedge aclk) disable iff (!aresetn)
        (!tx_ctrl[sbrg_pkg::SYNC_BIT] && (rate_ctrl[sbrg_pkg::WIDE_DIV_BIT] ^ tx_ctrl[sbrg_pkg::HIGH_SPEED_BIT]))
        |-> cfg.mode == sbrg_pkg::SBRG_DIV16)
        else $error("one select bit must give divide by sixteen");
endmodule
`default_nettype wire

// ---- verif/sbrg_line_peer.sv ----
// Serial line peer: drives the receive pin, with optional short disturbances
`timescale 1ns/1ps
`default_nettype none
module sbrg_line_peer (
    input wire logic aclk,
    input wire logic line_level,
    input wire logic glitch_go,
    input wire logic [7:0] glitch_len,
    output logic rx_pin
);
    logic [7:0] left = 8'h00;
    // Inverts the line for glitch_len cycles; the vote must reject this
    always_ff @(posedge aclk) begin
        if (glitch_go) begin
            left <= glitch_len;
        end else if (left != 8'h00) begin
            left <= left - 8'h01;
        end
    end
    assign rx_pin = (left != 8'h00) ? !line_level : line_level;
endmodule
`default_nettype wire

// ---- verif/serial_baud_rate_generator_tb.sv ----
// Self-checking bench for the baud rate generator: registers, bit rates, receive vote
`timescale 1ns/1ps
`default_nettype none
module serial_baud_rate_generator_tb;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h00000000;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, rx_pin, rate_tick, sample_tick, rx_level;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic line_level = 1'b1;
    logic glitch_go = 1'b0;
    int failures = 0;
    int samples_checked = 0;
    integer seed = 32'h8814;

    // 25 MHz device clock
    always #20 aclk = ~aclk;

    sbrg_top sbrg_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_pin(rx_pin),
        .rate_tick(rate_tick), .sample_tick(sample_tick), .rx_level(rx_level));

    sbrg_line_peer sbrg_line_peer_inst (.aclk(aclk), .line_level(line_level), .glitch_go(glitch_go),
        .glitch_len(8'h04), .rx_pin(rx_pin));

    // Prescale per mode; sync ignores high speed
    function automatic int exp_pre(input logic s, input logic h, input logic w);
        if (s || (h && w)) return 4;
        if (h || w) return 16;
        return 64;
    endfunction

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
            failures++;
        end
    endtask

    task automatic report_and_stop();
        if (failures == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // Write address and data offered together, each released once taken
    task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic [1:0] resp);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h000000, d};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        // Waits as long as the slave needs; only the watchdog ends a hang
        do begin
            @(posedge aclk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
        resp = bresp;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready === 1'b1) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
        d = rdata;
        resp = rresp;
    endtask

    // Mode first; the low byte last so its write restarts the divider
    task automatic setup(input logic s, input logic h, input logic w, input logic [7:0] hi, input logic [7:0] lo);
        logic [1:0] r;
        wr(sbrg_pkg::ADDR_TX_CTRL, {3'h0, s, 1'b0, h, 2'h0}, r);
        wr(sbrg_pkg::ADDR_RATE_CTRL, {4'h0, w, 3'h0}, r);
        wr(sbrg_pkg::ADDR_DIV_HIGH, hi, r);
        wr(sbrg_pkg::ADDR_DIV_LOW, lo, r);
    endtask

    // Cycles up to the next bit tick, with prescale ticks seen meanwhile
    task automatic wait_tick(output int c, output int subs);
        c = 0;
        subs = 0;
        do begin
            @(posedge aclk);
            c++;
            if (sample_tick === 1'b1) subs++;
        end while (rate_tick !== 1'b1 && c < 20000);
    endtask

    initial begin
        logic [1:0] r;
        logic [31:0] d;
        logic [7:0] hi, lo, a;
        int per, subs, gap, ep;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Reset values; receive idle reads high in rate control
        rd(sbrg_pkg::ADDR_TX_CTRL, d, r);
        check("transmit_status_control", {24'h0, sbrg_pkg::RST_TX_CTRL}, d);
        rd(sbrg_pkg::ADDR_RX_CTRL, d, r);
        check("receive_status_control", {24'h0, sbrg_pkg::RST_RX_CTRL}, d);
        rd(sbrg_pkg::ADDR_RATE_CTRL, d, r);
        check("rate_control", {24'h0, sbrg_pkg::RST_RATE_CTRL}, d);
        rd(sbrg_pkg::ADDR_DIV_HIGH, d, r);
        check("divisor_high_byte", {24'h0, sbrg_pkg::RST_DIVISOR}, d);
        rd(sbrg_pkg::ADDR_DIV_LOW, d, r);
        check("divisor_low_byte", {24'h0, sbrg_pkg::RST_DIVISOR}, d);
        // Zero divisor keeps the live count at zero
        rd(sbrg_pkg::ADDR_STATUS, d, r);
        check("divider count", 32'h00000000, d);
        // Random read-back of storage registers
        for (int i = 0; i < 6; i++) begin
            a = (i % 3 == 0) ? sbrg_pkg::ADDR_DIV_HIGH
                : (i % 3 == 1) ? sbrg_pkg::ADDR_DIV_LOW : sbrg_pkg::ADDR_RX_CTRL;
            hi = 8'($random(seed));
            wr(a, hi, r);
            check("write resp", {30'h0, sbrg_pkg::RESP_OKAY}, {30'h0, r});
            rd(a, d, r);
            check("read resp", {30'h0, sbrg_pkg::RESP_OKAY}, {30'h0, r});
            check("register read-back", {24'h0, hi}, d);
        end
        // Unmapped place answers with an error and zero data
        wr(8'h18, 8'h5a, r);
        check("unmapped write resp", {30'h0, sbrg_pkg::RESP_SLVERR}, {30'h0, r});
        rd(8'h18, d, r);
        check("unmapped read resp", {30'h0, sbrg_pkg::RESP_SLVERR}, {30'h0, r});
        check("unmapped read data", 32'h00000000, d);
        // Every mode combination; the ninth case is the 40 MHz check vector, 64*65 cycles
        for (int k = 0; k < 9; k++) begin
            hi = 8'($random(seed));
            lo = (k == 8) ? 8'h40 : 8'($random(seed)) & 8'h0f;
            if (k[0]) hi = hi & 8'h01;
            setup(k[2], k[1], k[0], hi, lo);
            wait_tick(gap, subs);
            wait_tick(per, subs);
            gap = k[0] ? int'({hi, lo}) : int'(lo);
            ep = exp_pre(k[2], k[1], k[0]);
            check("rate_tick period", 32'(ep * (gap + 1)), 32'(per));
            check("prescale ticks per bit", 32'(ep), 32'(subs));
        end
        // Divisor rewrite mid-period takes effect without the old expiry
        setup(1'b0, 1'b1, 1'b0, 8'h00, 8'hc8);
        wait_tick(gap, subs);
        repeat (100) @(posedge aclk);
        wr(sbrg_pkg::ADDR_DIV_LOW, 8'h02, r);
        wait_tick(gap, subs);
        check("restart gap in range", 32'h1, 32'((gap >= 40) && (gap <= 52)));
        wait_tick(per, subs);
        check("period after rewrite", 32'd48, 32'(per));
        // Receive vote: one disturbed sample in three is outvoted
        setup(1'b1, 1'b0, 1'b0, 8'h00, 8'h03);
        line_level <= 1'b0;
        repeat (4) wait_tick(gap, subs);
        check("rx_level low", 32'h0, {31'h0, rx_level});
        for (int i = 0; i < 10; i++) begin
            repeat (5) @(posedge aclk);
            glitch_go <= 1'b1;
            @(posedge aclk);
            glitch_go <= 1'b0;
            wait_tick(gap, subs);
            repeat (2) @(posedge aclk);
            check("rx_level under disturbance", 32'h0, {31'h0, rx_level});
        end
        rd(sbrg_pkg::ADDR_RATE_CTRL, d, r);
        check("rate_control voted low", 32'h00000000, d);
        line_level <= 1'b1;
        repeat (3) wait_tick(gap, subs);
        rd(sbrg_pkg::ADDR_RATE_CTRL, d, r);
        check("rate_control voted high", 32'h00000040, d);
        report_and_stop();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        #(40 * 60000);
        failures++;
        report_and_stop();
    end
endmodule
`default_nettype wire
